// [shared/status_readout_map.vh]
// register map and field constants for the system status readout
//
// Summary of operation
// - input voltage in word one bits 31-16, /10
// - decoded speed command in bits 15-1
// - bit 0 set when pin sequence entered
// - 4-bit state code in word two bits 31-28
// - codes 0..F as listed, B never reported
// - bit 17 set when self-test failed
// - electrical speed in bits 15-0, /10
// - word one at index E4, read-only, reset zero
// - word two at index EA, read-only, reset zero
`ifndef STATUS_READOUT_MAP_VH
`define STATUS_READOUT_MAP_VH

// ======================================================================
// register indices; byte address is four times the index
`define IDX_STATUS_VOLT_CMD 8'hE4
`define IDX_STATUS_STATE_SPEED 8'hEA
`define IDX_EVENT_STATUS 8'hF0
`define IDX_EVENT_MASK 8'hF1
`define ADDR_LSB 2
`define ADDR_IDX_W 8

// ======================================================================
// field positions, word one
`define VOLT_HI 31
`define VOLT_LO 16
`define CMD_HI 15
`define CMD_LO 1
`define ENTRY_BIT 0

// ======================================================================
// field positions, word two
`define STATE_HI 31
`define STATE_LO 28
`define STL_BIT 17
`define MSPEED_HI 15
`define MSPEED_LO 0

// ======================================================================
// state codes
`define ST_SYSTEM_IDLE 4'h0
`define ST_MOTOR_START 4'h1
`define ST_MOTOR_RUN 4'h2
`define ST_SYSTEM_INIT 4'h3
`define ST_POSITION_DETECT 4'h4
`define ST_MOTOR_ALIGN 4'h5
`define ST_MOTOR_IDLE 4'h6
`define ST_MOTOR_STOP 4'h7
`define ST_FAULT 4'h8
`define ST_DIRECTION 4'h9
`define ST_SENSOR_ALIGN 4'hA
`define ST_UNUSED 4'hB
`define ST_COASTING 4'hC
`define ST_DECELERATING 4'hD
`define ST_BRAKING 4'hE
`define ST_NOT_APPLICABLE 4'hF

// ======================================================================
// event bits in the event status and mask registers
`define EV_STATE_CHANGE 0
`define EV_FAULT_ENTRY 1
`define EV_SELF_TEST_FAIL 2
`define EV_SERIAL_ENTRY 3
`define EV_COUNT 4

// ======================================================================
// reset values
`define RESET_WORD 32'h0000_0000
`define RESET_STATE 4'h0
`define RESET_EVENTS 4'h0

`endif

// [core/sticky_event_bit.v]
// one sticky event flag, set by hardware, cleared by writing one
`timescale 1ns/1ps
module sticky_event_bit (
  input wire clk_in,
  input wire reset_n_in,
  input wire set_in,
  input wire clear_in,
  output wire flag_out
);
  reg flag_q;
  reg flag_d;

  // set beats clear so an event in the clear cycle survives
  always @* begin
    flag_d = flag_q;
    if (clear_in) begin
      flag_d = 1'b0;
    end
    if (set_in) begin
      flag_d = 1'b1;
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;
endmodule

// [core/system_status_readout.v]
// apb bank of two read-only system status words with event interrupt
`timescale 1ns/1ps
`include "status_readout_map.vh"
module system_status_readout #(
  parameter ADDR_W = 12
) (
  input wire clk_in,
  input wire reset_n_in,
  // ======================================================================
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output wire pready_out,
  output wire [31:0] prdata_out,
  output wire pslverr_out,
  // ======================================================================
  // status sources from the controller core
  input wire [15:0] input_voltage_value_in,
  input wire [14:0] speed_cmd_value_in,
  input wire serial_entry_by_pins_in,
  input wire [3:0] controller_state_in,
  input wire self_test_fail_flag_in,
  input wire [15:0] motor_speed_value_in,
  // ======================================================================
  // interrupt
  output wire irq_out
);

  // ======================================================================
  // captured status fields
  reg [15:0] volt_q;
  reg [14:0] cmd_q;
  reg entry_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg stl_q;
  reg [15:0] mspeed_q;

  // code B is never reported; keep the last legal code instead
  always @* begin
    case (controller_state_in)
      `ST_UNUSED: state_d = state_q;
      default: state_d = controller_state_in;
    endcase
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      volt_q <= 16'h0000;
      cmd_q <= 15'h0000;
      entry_q <= 1'b0;
      state_q <= `RESET_STATE;
      stl_q <= 1'b0;
      mspeed_q <= 16'h0000;
    end else begin
      volt_q <= input_voltage_value_in;
      cmd_q <= speed_cmd_value_in;
      entry_q <= serial_entry_by_pins_in;
      state_q <= state_d;
      stl_q <= self_test_fail_flag_in;
      mspeed_q <= motor_speed_value_in;
    end
  end

  // ======================================================================
  // assembled words; reserved bits tied to zero
  wire [31:0] word_volt_cmd;
  wire [31:0] word_state_speed;

  assign word_volt_cmd = {volt_q, cmd_q, entry_q};
  assign word_state_speed = {state_q, 10'h000, stl_q, 1'b0, mspeed_q};

  // ======================================================================
  // event detection
  reg stl_prev_q;
  reg entry_prev_q;
  reg [3:0] state_prev_q;
  wire [`EV_COUNT-1:0] ev_set;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stl_prev_q <= 1'b0;
      entry_prev_q <= 1'b0;
      state_prev_q <= `RESET_STATE;
    end else begin
      stl_prev_q <= stl_q;
      entry_prev_q <= entry_q;
      state_prev_q <= state_q;
    end
  end

  assign ev_set[`EV_STATE_CHANGE] = (state_q != state_prev_q);
  assign ev_set[`EV_FAULT_ENTRY] = (state_q == `ST_FAULT) && (state_prev_q != `ST_FAULT);
  assign ev_set[`EV_SELF_TEST_FAIL] = stl_q && !stl_prev_q;
  assign ev_set[`EV_SERIAL_ENTRY] = entry_q && !entry_prev_q;

  // ======================================================================
  // apb decode
  wire [`ADDR_IDX_W-1:0] idx;
  wire setup_phase;
  wire access_phase;
  wire hit_volt_cmd;
  wire hit_state_speed;
  wire hit_ev_status;
  wire hit_ev_mask;
  wire hit_any;
  wire addr_in_range;

  assign idx = paddr_in[`ADDR_LSB+`ADDR_IDX_W-1:`ADDR_LSB];
  // upper address bits beyond the index must be zero, low two bits too
  assign addr_in_range = (paddr_in[`ADDR_LSB-1:0] == 2'b00) &&
                         ((paddr_in >> (`ADDR_LSB + `ADDR_IDX_W)) == {ADDR_W{1'b0}});
  assign setup_phase = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in;
  assign hit_volt_cmd = addr_in_range && (idx == `IDX_STATUS_VOLT_CMD);
  assign hit_state_speed = addr_in_range && (idx == `IDX_STATUS_STATE_SPEED);
  assign hit_ev_status = addr_in_range && (idx == `IDX_EVENT_STATUS);
  assign hit_ev_mask = addr_in_range && (idx == `IDX_EVENT_MASK);
  assign hit_any = hit_volt_cmd || hit_state_speed || hit_ev_status || hit_ev_mask;

  // ======================================================================
  // event status and mask
  wire [`EV_COUNT-1:0] ev_flags;
  wire [`EV_COUNT-1:0] ev_clear;
  wire wr_take;
  reg [`EV_COUNT-1:0] mask_q;

  // write effect at the single access edge; pready is always high
  assign wr_take = access_phase && pwrite_in;
  assign ev_clear = (wr_take && hit_ev_status && pstrb_in[0]) ?
                    pwdata_in[`EV_COUNT-1:0] : `RESET_EVENTS;

  genvar g;
  generate
    for (g = 0; g < `EV_COUNT; g = g + 1) begin : g_ev
      sticky_event_bit u_flag (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .set_in(ev_set[g]),
        .clear_in(ev_clear[g]),
        .flag_out(ev_flags[g])
      );
    end
  endgenerate

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_q <= `RESET_EVENTS;
    end else if (wr_take && hit_ev_mask && pstrb_in[0]) begin
      mask_q <= pwdata_in[`EV_COUNT-1:0];
    end
  end

  assign irq_out = |(ev_flags & mask_q);

  // ======================================================================
  // read data and error, captured in the setup cycle
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg err_q;

  // status words ignore writes entirely; only reads see them
  always @* begin
    rdata_d = 32'h0000_0000;
    if (!pwrite_in) begin
      if (hit_volt_cmd) begin
        rdata_d = word_volt_cmd;
      end else if (hit_state_speed) begin
        rdata_d = word_state_speed;
      end else if (hit_ev_status) begin
        rdata_d = {{(32-`EV_COUNT){1'b0}}, ev_flags};
      end else if (hit_ev_mask) begin
        rdata_d = {{(32-`EV_COUNT){1'b0}}, mask_q};
      end
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= `RESET_WORD;
      err_q <= 1'b0;
    end else if (setup_phase) begin
      rdata_q <= rdata_d;
      // unmapped index answers with an error, data zero
      err_q <= !hit_any;
    end
  end

  assign pready_out = 1'b1;
  assign prdata_out = rdata_q;
  assign pslverr_out = access_phase && err_q;

endmodule

// [test/system_status_readout_props.sv]
// port-level assertions for the system status readout
`timescale 1ns/1ps
module system_status_readout_props #(
  parameter ADDR_W = 12
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  input wire pready_out,
  input wire [31:0] prdata_out,
  input wire pslverr_out,
  input wire [15:0] input_voltage_value_in,
  input wire [14:0] speed_cmd_value_in,
  input wire serial_entry_by_pins_in,
  input wire [3:0] controller_state_in,
  input wire self_test_fail_flag_in,
  input wire [15:0] motor_speed_value_in,
  input wire irq_out
);
  // ==========================================================
  // helpers; status words show inputs from the edge before setup
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire acc = psel_in && penable_in;
  wire rd_setup = psel_in && !penable_in && !pwrite_in && reset_n_in;
  wire mapped = paddr_in == 12'h390 || paddr_in == 12'h3a8 || paddr_in == 12'h3c0 ||
    paddr_in == 12'h3c4;
  a_ready_always: assert property (pready_out) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (acc && mapped |-> !pslverr_out) else $error("false error");
  a_read_word1: assert property (rd_setup && paddr_in == 12'h390 && $past(reset_n_in) |=>
    prdata_out == {$past(input_voltage_value_in, 2), $past(speed_cmd_value_in, 2),
    $past(serial_entry_by_pins_in, 2)}) else $error("word one wrong");
  a_read_word2: assert property (rd_setup && paddr_in == 12'h3a8 && $past(reset_n_in) |=>
    prdata_out[27:0] == {10'h000, $past(self_test_fail_flag_in, 2), 1'b0,
    $past(motor_speed_value_in, 2)}) else $error("word two wrong");
  a_state_code: assert property (rd_setup && paddr_in == 12'h3a8 && $past(reset_n_in) &&
    $past(controller_state_in) != 4'hb |=> prdata_out[31:28] == $past(controller_state_in, 2))
    else $error("state code wrong");
  a_no_code_b: assert property (acc && paddr_in == 12'h3a8 |-> prdata_out[31:28] != 4'hb)
    else $error("code b reported");
  a_data_holds: assert property (acc |=> $stable(prdata_out)) else $error("read data moved");
  a_mask_off: assert property (acc && pwrite_in && pstrb_in[0] && paddr_in == 12'h3c4 &&
    pwdata_in[3:0] == 4'h0 |=> !irq_out) else $error("irq with mask clear");
  a_reset_clear: assert property ($rose(reset_n_in) |-> prdata_out == 32'h0 && !irq_out)
    else $error("not cleared by reset");
  cover property (rd_setup && paddr_in == 12'h390);
  cover property (acc && !mapped);
  cover property ($rose(irq_out));
endmodule
bind system_status_readout system_status_readout_props #(.ADDR_W(ADDR_W)) props (.*);

// [test/system_status_readout_tb.sv]
// self-checking bench for the system status readout
`timescale 1ns/1ps
module system_status_readout_tb;
  logic clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, er;
  logic serial_entry_by_pins_in = 0, self_test_fail_flag_in = 0;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, rd;
  logic [3:0] pstrb_in = 4'hf, controller_state_in = 0;
  logic [15:0] input_voltage_value_in = 0, motor_speed_value_in = 0;
  logic [14:0] speed_cmd_value_in = 0;
  wire pready_out, pslverr_out, irq_out;
  wire [31:0] prdata_out;
  int err_count = 0, n_compared = 0;
  typedef struct packed {logic [15:0] v; logic [14:0] c; logic e; logic [3:0] s; logic f;
    logic [15:0] sp; logic [31:0] w1, w2;} row_t;
  row_t rows [4] = '{'0,
    '{16'h00f0, 15'h7fff, 1'b1, 4'h2, 1'b0, 16'h7530, 32'h00f0_ffff, 32'h2000_7530},
    '{16'hffff, 15'h0000, 1'b0, 4'h8, 1'b1, 16'hffff, 32'hffff_0000, 32'h8002_ffff},
    '{16'h0001, 15'h4000, 1'b0, 4'he, 1'b0, 16'h0001, 32'h0001_8000, 32'he000_0001}};
  system_status_readout DUT (.*);
  always #5 clk_in = ~clk_in;
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one transfer; no wait count assumed, the watchdog cuts a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  task automatic drive(input row_t r);
    @(posedge clk_in);
    input_voltage_value_in <= r.v;
    speed_cmd_value_in <= r.c;
    serial_entry_by_pins_in <= r.e;
    controller_state_in <= r.s;
    self_test_fail_flag_in <= r.f;
    motor_speed_value_in <= r.sp;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
  // ==========================================================
  // table, then hand-written cases
  initial begin
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1;
    foreach (rows[i]) begin
      drive(rows[i]);
      apb(0, 12'h390, 0);
      chk(rd, rows[i].w1);
      chk({31'h0, er}, 0);
      apb(0, 12'h3a8, 0);
      chk(rd, rows[i].w2);
    end
    for (int s = 0; s < 16; s++) begin
      @(posedge clk_in);
      controller_state_in <= s[3:0];
      repeat (2) @(posedge clk_in);
      apb(0, 12'h3a8, 0);
      chk(rd >> 28, (s == 11) ? 10 : s);
    end
    apb(1, 12'h390, 32'hffff_ffff);
    apb(1, 12'h3a8, 32'hffff_ffff);
    apb(0, 12'h390, 0);
    chk(rd, rows[3].w1);
    apb(0, 12'h394, 0);
    chk({31'h0, er}, 1);
    chk(rd, 0);
    apb(1, 12'h3c0, 32'h0000_000f);
    apb(1, 12'h3c4, 32'h0000_0001);
    @(negedge clk_in);
    chk(irq_out, 0);
    @(posedge clk_in);
    controller_state_in <= 4'h2;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk(irq_out, 1);
    apb(1, 12'h3c4, 0);
    @(negedge clk_in);
    chk(irq_out, 0);
    apb(0, 12'h3c0, 0);
    chk(rd, 1);
    apb(1, 12'h3c0, 1);
    apb(1, 12'h3c4, 1);
    @(negedge clk_in);
    chk(irq_out, 0);
    apb(0, 12'h390, 0);
    reset_n_in <= 0;
    @(negedge clk_in);
    chk(prdata_out, 0);
    @(posedge clk_in);
    reset_n_in <= 1;
    report_and_stop();
  end
endmodule
